// *** src/lac_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module lac_edge_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] chg_o
);

  if (W < 1) begin : g_chk
    $error("lac_edge_sync: width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } lac_sync_t;

  lac_sync_t r;
  lac_sync_t next_r;

  // s1 feeds s2 only; s3 is the delayed copy used for change detection
  always_comb begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // both edges count as a transition
  assign q_o = r.s2;
  assign chg_o = r.s2 ^ r.s3;

endmodule

`default_nettype wire

// *** src/lac_pkg.sv ***
package lac_pkg;

  // soft reset sequencer
  typedef enum logic {
    LAC_IDLE,
    LAC_SRST
  } lac_rst_st_t;

endpackage

// *** src/lac_regs.svh ***
`ifndef LAC_REGS_SVH
`define LAC_REGS_SVH

// register offsets on the host port
`define LAC_ADDR_LOS_STAT 8'h04
`define LAC_ADDR_DF_STAT 8'h05
`define LAC_ADDR_LOS_MASK 8'h06
`define LAC_ADDR_DF_MASK 8'h07
`define LAC_ADDR_LOS_IRQ 8'h08
`define LAC_ADDR_DF_IRQ 8'h09
`define LAC_ADDR_SRST 8'h0a
`define LAC_ADDR_MON 8'h0b
`define LAC_ADDR_DLB 8'h0c
`define LAC_ADDR_CRIT 8'h0d
`define LAC_ADDR_ATO 8'h0e
`define LAC_ADDR_GLOB 8'h0f

// reset values
`define LAC_RST_CHAN 4'h0
`define LAC_RST_MON 4'h0
`define LAC_RST_GLOB 7'h00
`define LAC_SRST_READ 8'hff

// global settings field positions and attenuator placement codes
`define LAC_GLB_AIS 6
`define LAC_GLB_SCP 5
`define LAC_GLB_CODE 4
`define LAC_GLB_DEPTH 3
`define LAC_GLB_BW 2
`define LAC_GLB_PLC_HI 1
`define LAC_GLB_PLC_LO 0
`define LAC_JA_TX 2'h1
`define LAC_JA_RX 2'h3

// monitor code fields
`define LAC_MON_DIR 3
`define LAC_MON_RSV 2

// soft reset length and clock rate
`define LAC_SRST_NS 1000
`define LAC_CLK_MHZ 20

`endif

// *** src/lac_regs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lac_regs.svh"

module lac_regs_top #(
  parameter int NCH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [NCH-1:0] los_i,
  input wire logic [NCH-1:0] df_i,
  input wire logic t1_mode_i,
  output logic irq_o,
  output logic srst_busy_o,
  output logic [NCH-1:0] dlb_o,
  output logic [NCH-1:0] crit_etsi_o,
  output logic [NCH-1:0] tx_all_ones_o,
  output logic [NCH-1:0] ais_insert_o,
  output logic short_protect_disable_o,
  output logic line_code_ami_o,
  output logic fifo_depth64_o,
  output logic bw_high_o,
  output logic ja_tx_o,
  output logic ja_rx_o,
  output logic mon_en_o,
  output logic mon_tx_o,
  output logic [1:0] mon_chan_o
);

  // the channel fields live in the low nibble of byte-wide registers
  if (NCH < 1 || NCH > 4) begin : g_chk
    $error("lac_regs_top: channel count must be 1 to 4");
  end

  // 1 us rounded up to whole cycles
  localparam int SRST_CYC = (`LAC_SRST_NS * `LAC_CLK_MHZ + 999) / 1000;
  localparam int CW = $clog2(SRST_CYC + 1);

  if (SRST_CYC < 1) begin : g_chk_srst
    $error("lac_regs_top: soft reset must last at least one cycle");
  end

  typedef struct packed {
    logic [NCH-1:0] los_mask;
    logic [NCH-1:0] df_mask;
    logic [NCH-1:0] los_lat;
    logic [NCH-1:0] df_lat;
    logic [3:0] mon_code;
    logic [NCH-1:0] digital_loopback_enable;
    logic [NCH-1:0] crit;
    logic [NCH-1:0] ato;
    logic [6:0] glob;
    lac_pkg::lac_rst_st_t st;
    logic [CW-1:0] cnt;
    logic [7:0] rdata;
  } lac_state_t;

  lac_state_t r;
  lac_state_t next_r;

  logic [NCH-1:0] los_s;
  logic [NCH-1:0] df_s;
  logic [NCH-1:0] los_chg;
  logic [NCH-1:0] df_chg;
  logic t1_s;
  logic t1_chg;
  logic [7:0] rd_val;
  logic busy;

  // line alarms and the mode strap come from outside this clock
  lac_edge_sync #(
    .W(2 * NCH + 1)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({t1_mode_i, df_i, los_i}),
    .q_o({t1_s, df_s, los_s}),
    .chg_o({t1_chg, df_chg, los_chg})
  );

  assign busy = (r.st == lac_pkg::LAC_SRST);

  // set beats clear so an edge landing on the status read is kept
  function automatic logic [NCH-1:0] lac_latch(
    input logic [NCH-1:0] held,
    input logic [NCH-1:0] chg,
    input logic [NCH-1:0] mask,
    input logic clr
  );
    lac_latch = (clr ? '0 : held) | (chg & mask);
  endfunction

  // widen a channel field to a byte, upper bits read as zero
  function automatic logic [7:0] lac_byte(input logic [NCH-1:0] f);
    lac_byte = 8'(f);
  endfunction

  // read data mux; unmapped offsets read as zero
  always_comb begin
    case (addr_i)
      `LAC_ADDR_LOS_STAT: rd_val = lac_byte(los_s);
      `LAC_ADDR_DF_STAT: rd_val = lac_byte(df_s);
      `LAC_ADDR_LOS_MASK: rd_val = lac_byte(r.los_mask);
      `LAC_ADDR_DF_MASK: rd_val = lac_byte(r.df_mask);
      `LAC_ADDR_LOS_IRQ: rd_val = lac_byte(r.los_lat);
      `LAC_ADDR_DF_IRQ: rd_val = lac_byte(r.df_lat);
      `LAC_ADDR_SRST: rd_val = `LAC_SRST_READ;
      `LAC_ADDR_MON: rd_val = {4'h0, r.mon_code};
      `LAC_ADDR_DLB: rd_val = lac_byte(r.digital_loopback_enable);
      `LAC_ADDR_CRIT: rd_val = lac_byte(r.crit);
      `LAC_ADDR_ATO: rd_val = lac_byte(r.ato);
      `LAC_ADDR_GLOB: rd_val = {1'b0, r.glob};
      default: rd_val = 8'h00;
    endcase
  end

  // register file, interrupt latches and soft reset sequencer
  always_comb begin
    next_r = r;
    if (busy) begin
      // every register but the sequencer state and the read latch is reloaded with its default on each busy cycle
      next_r.los_mask = `LAC_RST_CHAN;
      next_r.df_mask = `LAC_RST_CHAN;
      next_r.los_lat = `LAC_RST_CHAN;
      next_r.df_lat = `LAC_RST_CHAN;
      next_r.mon_code = `LAC_RST_MON;
      next_r.digital_loopback_enable = `LAC_RST_CHAN;
      next_r.crit = `LAC_RST_CHAN;
      next_r.ato = `LAC_RST_CHAN;
      next_r.glob = `LAC_RST_GLOB;
      if (r.cnt == '0) begin
        next_r.st = lac_pkg::LAC_IDLE;
      end else begin
        next_r.cnt = r.cnt - CW'(1);
      end
    end else begin
      // reading the status register clears the matching latches
      next_r.los_lat = lac_latch(r.los_lat, los_chg, r.los_mask,
        rd_en_i && addr_i == `LAC_ADDR_LOS_STAT);
      next_r.df_lat = lac_latch(r.df_lat, df_chg, r.df_mask,
        rd_en_i && addr_i == `LAC_ADDR_DF_STAT);
      // upper nibble is not stored (the global register drops only bit 7), so reserved bits stay zero
      if (wr_en_i) begin
        case (addr_i)
          `LAC_ADDR_LOS_MASK: next_r.los_mask = wdata_i[NCH-1:0];
          `LAC_ADDR_DF_MASK: next_r.df_mask = wdata_i[NCH-1:0];
          `LAC_ADDR_SRST: begin
            next_r.st = lac_pkg::LAC_SRST;
            next_r.cnt = CW'(SRST_CYC - 1);
          end
          `LAC_ADDR_MON: next_r.mon_code = wdata_i[3:0];
          `LAC_ADDR_DLB: next_r.digital_loopback_enable = wdata_i[NCH-1:0];
          `LAC_ADDR_CRIT: next_r.crit = wdata_i[NCH-1:0];
          `LAC_ADDR_ATO: next_r.ato = wdata_i[NCH-1:0];
          `LAC_ADDR_GLOB: next_r.glob = wdata_i[6:0];
          default: next_r.glob = r.glob;
        endcase
      end
    end
    // a read loads the read latch; a status read also clears its interrupt latches
    if (rd_en_i) begin
      next_r.rdata = rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r.los_mask <= `LAC_RST_CHAN;
      r.df_mask <= `LAC_RST_CHAN;
      r.los_lat <= `LAC_RST_CHAN;
      r.df_lat <= `LAC_RST_CHAN;
      r.mon_code <= `LAC_RST_MON;
      r.digital_loopback_enable <= `LAC_RST_CHAN;
      r.crit <= `LAC_RST_CHAN;
      r.ato <= `LAC_RST_CHAN;
      r.glob <= `LAC_RST_GLOB;
      r.st <= lac_pkg::LAC_IDLE;
      r.cnt <= '0;
      r.rdata <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // interrupt is a level that drops only when both latches are empty
  assign irq_o = |{r.los_lat, r.df_lat};
  assign srst_busy_o = busy;
  assign rdata_o = r.rdata;

  // per-channel controls; the T1 criterion is fixed, hence the mask
  assign dlb_o = r.digital_loopback_enable;
  assign crit_etsi_o = r.crit & {NCH{~t1_s}};
  // all ones follows the synchronised loss level, two cycles behind the pin
  assign tx_all_ones_o = r.ato & los_s;
  assign ais_insert_o = {NCH{r.glob[`LAC_GLB_AIS]}} & los_s;

  // global settings
  assign short_protect_disable_o = r.glob[`LAC_GLB_SCP];
  assign line_code_ami_o = r.glob[`LAC_GLB_CODE];
  assign fifo_depth64_o = r.glob[`LAC_GLB_DEPTH];
  assign bw_high_o = r.glob[`LAC_GLB_BW];
  assign ja_tx_o = r.glob[`LAC_GLB_PLC_HI:`LAC_GLB_PLC_LO] == `LAC_JA_TX;
  assign ja_rx_o = r.glob[`LAC_GLB_PLC_HI:`LAC_GLB_PLC_LO] == `LAC_JA_RX;

  // reserved monitor codes fall back to no monitoring
  assign mon_en_o = !r.mon_code[`LAC_MON_RSV] && r.mon_code[1:0] != 2'h0;
  assign mon_tx_o = mon_en_o && r.mon_code[`LAC_MON_DIR];
  assign mon_chan_o = mon_en_o ? r.mon_code[1:0] : 2'h0;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  logic rd_los;
  logic wr_srst;
  assign rd_los = rd_en_i && addr_i == `LAC_ADDR_LOS_STAT;
  assign wr_srst = wr_en_i && addr_i == `LAC_ADDR_SRST && !busy;

  // write data slices that the write checks compare against
  logic [NCH-1:0] wr_chan;
  logic [3:0] wr_glob;
  logic [1:0] wr_place;
  assign wr_chan = wdata_i[NCH-1:0];
  assign wr_glob = wdata_i[`LAC_GLB_SCP:`LAC_GLB_BW];
  assign wr_place = wdata_i[`LAC_GLB_PLC_HI:`LAC_GLB_PLC_LO];

  a_los_mask_block: assert property (
    !busy && !(|(los_chg & r.los_mask)) && r.los_lat == '0 |=> r.los_lat == '0)
    else $error("signal-loss latch set while masked");

  a_df_mask_block: assert property (
    !busy && !(|(df_chg & r.df_mask)) && r.df_lat == '0 |=> r.df_lat == '0)
    else $error("driver-fault latch set while masked");

  a_los_latch_set: assert property (
    !busy && |(los_chg & r.los_mask) |=> (r.los_lat & $past(los_chg)) != '0)
    else $error("unmasked signal-loss change not latched");

  a_los_read_clear: assert property (
    !busy && rd_los && los_chg == '0 |=> r.los_lat == '0 ##1 1'b1)
    else $error("status read did not clear signal-loss latch");

  a_srst_length: assert property (
    wr_srst |=> busy ##19 busy ##1 !busy)
    else $error("soft reset length wrong");

  a_srst_defaults: assert property (
    busy |=> r.los_mask == '0 && r.digital_loopback_enable == '0 && r.glob == '0 && r.mon_code == '0)
    else $error("register not at default during soft reset");

  a_mon_reserved: assert property (
    r.mon_code[`LAC_MON_RSV] || r.mon_code[1:0] == 2'h0 |-> !mon_en_o && !mon_tx_o)
    else $error("reserved monitor code enabled monitoring");

  a_crit_t1: assert property (
    t1_s |-> crit_etsi_o == '0)
    else $error("ETSI criterion active in T1 mode");

  a_all_ones_los: assert property (
    (tx_all_ones_o & ~los_s) == '0 && (ais_insert_o & ~los_s) == '0)
    else $error("all ones or AIS without signal loss");

  a_irq_raise: assert property (
    !busy && |(df_chg & r.df_mask) |=> irq_o)
    else $error("interrupt not raised on latched event");

  a_srst_read: assert property (
    !busy && rd_en_i && !wr_en_i && addr_i == `LAC_ADDR_SRST |=>
      $stable(r.los_mask) && $stable(r.glob) && !busy && rdata_o == 8'hff)
    else $error("soft reset read disturbed state");

  a_df_latch_set: assert property (
    !busy && |(df_chg & r.df_mask) |=> (r.df_lat & $past(df_chg)) != '0)
    else $error("unmasked driver-fault change not latched");

  a_df_read_clear: assert property (
    !busy && rd_en_i && addr_i == `LAC_ADDR_DF_STAT && df_chg == '0 |=> r.df_lat == '0)
    else $error("status read did not clear driver-fault latch");

  a_irq_release: assert property (
    !busy && rd_los && los_chg == '0 && r.df_lat == '0 && !(|(df_chg & r.df_mask)) |=>
      !irq_o)
    else $error("interrupt held after all latches cleared");

  // checks on what a write leaves behind
  a_dlb_write: assert property (
    !busy && wr_en_i && addr_i == `LAC_ADDR_DLB |=> dlb_o == $past(wr_chan))
    else $error("loopback enable did not follow write");

  a_busy_write_drop: assert property (
    busy && wr_en_i && addr_i == `LAC_ADDR_DLB |=> dlb_o == '0)
    else $error("write accepted during soft reset");

  a_glob_write: assert property (
    !busy && wr_en_i && addr_i == `LAC_ADDR_GLOB |=>
      {short_protect_disable_o, line_code_ami_o, fifo_depth64_o, bw_high_o} == $past(wr_glob))
    else $error("global setting did not follow write");

  a_place_write: assert property (
    !busy && wr_en_i && addr_i == `LAC_ADDR_GLOB |=>
      ja_tx_o == ($past(wr_place) == 2'h1) && ja_rx_o == ($past(wr_place) == 2'h3))
    else $error("attenuator placement did not follow write");

  a_ais_pin: assert property (
    $past(rstn_i) && $past(rstn_i, 2) |->
      ais_insert_o == ({NCH{r.glob[`LAC_GLB_AIS]}} & $past(los_i, 2)))
    else $error("alarm insertion does not follow line signal loss");

  a_all_ones_pin: assert property (
    $past(rstn_i) && $past(rstn_i, 2) |->
      tx_all_ones_o == (r.ato & $past(los_i, 2)))
    else $error("all ones does not follow line signal loss");

  c_los_irq: cover property (!busy && |(los_chg & r.los_mask) ##1 irq_o ##[1:20] rd_los);
  c_df_irq: cover property (!busy && |(df_chg & r.df_mask) ##1 irq_o);
  c_srst_run: cover property (wr_srst ##21 !busy);
  c_ja_rx: cover property (ja_rx_o && fifo_depth64_o);
  c_mon_tx: cover property (mon_tx_o && mon_chan_o == 2'h3);

endmodule

`default_nettype wire

// *** testbench/lac_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lac_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  // bus idle at time zero
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 8'h00;
  end

  // one-cycle write strobe; offsets 06 to 0e other than the soft reset register get a zero upper nibble
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a >= 8'h06 && a <= 8'h0e && a != 8'h0a) ? {4'h0, d[3:0]} : d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wdata_o <= ~d; // released data bus must not keep the old value
  endtask

  // read data lands on the edge after the strobe edge, so sample once it settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule

`default_nettype wire

// *** testbench/test_lac_regs_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_lac_regs_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } lac_row_t;
  logic clk_i;
  logic rstn_i;
  logic t1_mode_i;
  logic [3:0] los_i, df_i, digital_loopback_enable, crit, ato, ais;
  logic [7:0] addr, wdata, rdata, v;
  logic wr_en, rd_en, irq, busy, spd, ami, d64, bw, jtx, jrx, men, mtx;
  logic [1:0] mch;
  int errors;
  int n_tests;
  // write, read back; the unmapped and read-only rows must read zero
  lac_row_t rows [9] = '{'{8'h06, 8'h05, 8'h05}, '{8'h07, 8'h0a, 8'h0a},
    '{8'h0c, 8'h05, 8'h05}, '{8'h0d, 8'h03, 8'h03}, '{8'h0e, 8'h09, 8'h09},
    '{8'h0f, 8'hff, 8'h7f}, '{8'h0b, 8'h09, 8'h09}, '{8'h20, 8'h55, 8'h00},
    '{8'h08, 8'h0f, 8'h00}};

  lac_host_model i_lac_host_model (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .wdata_o(wdata), .rdata_i(rdata));

  lac_regs_top i_lac_regs_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata), .los_i(los_i),
    .df_i(df_i), .t1_mode_i(t1_mode_i), .irq_o(irq), .srst_busy_o(busy), .dlb_o(digital_loopback_enable),
    .crit_etsi_o(crit), .tx_all_ones_o(ato), .ais_insert_o(ais),
    .short_protect_disable_o(spd), .line_code_ami_o(ami), .fifo_depth64_o(d64),
    .bw_high_o(bw), .ja_tx_o(jtx), .ja_rx_o(jrx), .mon_en_o(men), .mon_tx_o(mtx),
    .mon_chan_o(mch));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #(50 * 20000);
    errors++;
    give_verdict();
  end

  initial begin
    rstn_i = 1'b0;
    t1_mode_i = 1'b0;
    los_i = 4'h0;
    df_i = 4'h0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    // register defaults after reset
    for (int a = 6; a < 16; a++) begin
      i_lac_host_model.rd(8'(a), v);
      chk("reset value", v, (a == 10) ? 8'hff : 8'h00);
    end
    $display("reset test done");
    // ordinary register rows
    foreach (rows[i]) begin
      i_lac_host_model.wr(rows[i].a, rows[i].d);
      i_lac_host_model.rd(rows[i].a, v);
      chk("readback", v, rows[i].e);
    end
    chk("loopback", {4'h0, digital_loopback_enable}, 8'h05);
    chk("globals", {2'h0, spd, ami, d64, bw, jtx, jrx}, 8'h3d);
    $display("row test done");
    // every monitor code, reserved ones included
    for (int c = 0; c < 16; c++) begin
      i_lac_host_model.wr(8'h0b, 8'(c));
      @(posedge clk_i);
      chk("monitor enable", {7'h0, men}, {7'h0, c[2] == 0 && c[1:0] != 0});
      chk("monitor chan", {6'h0, mch}, (c[2] == 0) ? {6'h0, 2'(c)} : 8'h00);
      if (men === 1'b1) chk("monitor dir", {7'h0, mtx}, {7'h0, c[3]});
    end
    $display("monitor test done");
    // placement 01 selects the transmit path
    i_lac_host_model.wr(8'h0f, 8'h7d);
    @(posedge clk_i);
    chk("placement", {6'h0, jtx, jrx}, 8'h02);
    // signal loss on ch0 (unmasked) and ch1 (masked)
    @(posedge clk_i);
    los_i <= 4'h3;
    repeat (6) @(posedge clk_i);
    #1 chk("irq on", {7'h0, irq}, 8'h01);
    chk("all ones", {4'h0, ato}, 8'h01);
    chk("ais insert", {4'h0, ais}, 8'h03);
    chk("criterion e1", {4'h0, crit}, 8'h03);
    i_lac_host_model.rd(8'h08, v);
    chk("loss latch", v, 8'h01);
    i_lac_host_model.rd(8'h04, v);
    chk("loss status", v, 8'h03);
    i_lac_host_model.rd(8'h08, v);
    chk("loss cleared", v, 8'h00);
    chk("irq off", {7'h0, irq}, 8'h00);
    // driver fault on ch1 (unmasked) and ch2 (masked)
    @(posedge clk_i);
    df_i <= 4'h6;
    repeat (6) @(posedge clk_i);
    i_lac_host_model.rd(8'h09, v);
    chk("fault latch", v, 8'h02);
    i_lac_host_model.rd(8'h05, v);
    chk("fault status", v, 8'h06);
    i_lac_host_model.rd(8'h09, v);
    chk("fault cleared", v, 8'h00);
    @(posedge clk_i);
    t1_mode_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("criterion t1", {4'h0, crit}, 8'h00);
    $display("alarm test done");
    // reading the reset register disturbs nothing
    i_lac_host_model.rd(8'h0a, v);
    chk("reset reg read", v, 8'hff);
    i_lac_host_model.rd(8'h0c, v);
    chk("after reset read", v, 8'h05);
    // soft reset: busy for a bounded time, then defaults everywhere
    i_lac_host_model.wr(8'h0a, 8'h3c);
    @(posedge clk_i);
    #1 chk("busy", {7'h0, busy}, 8'h01);
    i_lac_host_model.wr(8'h0c, 8'h0f);
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk_i);
    chk("busy ends", {7'h0, busy}, 8'h00);
    i_lac_host_model.rd(8'h0c, v);
    chk("soft reset dlb", v, 8'h00);
    i_lac_host_model.rd(8'h0f, v);
    chk("soft reset glob", v, 8'h00);
    i_lac_host_model.rd(8'h0a, v);
    chk("reset reg kept", v, 8'hff);
    $display("soft reset test done");
    // a hard reset in mid-run clears what the host wrote
    i_lac_host_model.wr(8'h0c, 8'h0a);
    @(posedge clk_i);
    chk("dlb before reset", {4'h0, digital_loopback_enable}, 8'h0a);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    i_lac_host_model.rd(8'h0c, v);
    chk("hard reset dlb", v, 8'h00);
    chk("hard reset irq busy", {6'h0, irq, busy}, 8'h00);
    $display("hard reset test done");
    give_verdict();
  end
endmodule

`default_nettype wire
